// File: design/alod_decoder.sv
// Purpose: Decode, time and execute the arithmetic and logic opcode groups
// Assumes: Fetch unit presents whole instructions, data memory reads combinationally
// Notes: Unknown opcodes are taken as one byte, one machine cycle, no effect

`timescale 1ns/100ps

module alod_decoder (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ins_valid,
   input  wire logic [7:0]  ins_opcode,
   input  wire logic [7:0]  ins_byte1,
   input  wire logic [7:0]  ins_byte2,
   output logic             ins_ready,
   output logic             consume,
   output logic [1:0]       consume_len,
   output logic             dmem_rd,
   output logic             dmem_wr,
   output logic [7:0]       dmem_addr,
   output logic [7:0]       dmem_wdata,
   input  wire logic [7:0]  dmem_rdata,
   input  wire logic        bank_load_en,
   input  wire logic [2:0]  bank_load_idx,
   input  wire logic [7:0]  bank_load_data,
   input  wire logic        acc_load_en,
   input  wire logic [7:0]  acc_load_data,
   input  wire logic        carry_load_en,
   input  wire logic        carry_load_data,
   output logic [7:0]       acc,
   output logic             carry,
   output logic             done,
   output logic [2:0]       done_mc,
   output logic             unsupported
);

   alod_pkg::alod_state_t s_q;
   alod_pkg::alod_state_t s_d;

   // Operation, operand source, length and timing of one opcode
   function automatic alod_pkg::alod_dec_t decode(input logic [7:0] opc);
      alod_pkg::alod_dec_t d;
      logic [3:0]          hi;
      logic [3:0]          lo;
      logic                arith;
      hi       = opc[7:4];
      lo       = opc[3:0];
      d        = '0;
      d.op     = alod_pkg::ALOD_OP_NONE;
      d.src    = alod_pkg::ALOD_SRC_REG;
      d.len    = alod_pkg::LEN_ONE;
      d.mc     = alod_pkg::MC_ONE;
      case (hi)
         alod_pkg::HI_ADD:  d.op = alod_pkg::ALOD_OP_ADD;
         alod_pkg::HI_SUM_WITH_CARRY_OP: d.op = alod_pkg::ALOD_OP_SUM_WITH_CARRY_OP;
         alod_pkg::HI_MINUS_WITH_BORROW_OP: d.op = alod_pkg::ALOD_OP_MINUS_WITH_BORROW_OP;
         alod_pkg::HI_AND:  d.op = alod_pkg::ALOD_OP_AND;
         alod_pkg::HI_OR:   d.op = alod_pkg::ALOD_OP_OR;
         alod_pkg::HI_XOR:  d.op = alod_pkg::ALOD_OP_XOR;
         default:           d.op = alod_pkg::ALOD_OP_NONE;
      endcase
      arith = (d.op == alod_pkg::ALOD_OP_ADD) || (d.op == alod_pkg::ALOD_OP_SUM_WITH_CARRY_OP) ||
              (d.op == alod_pkg::ALOD_OP_MINUS_WITH_BORROW_OP);
      if (d.op != alod_pkg::ALOD_OP_NONE) begin
         if (lo[alod_pkg::LO_REG_BIT]) begin
            // Bank register picked by the three low opcode bits
            d.valid = 1'b1;
            d.src   = alod_pkg::ALOD_SRC_REG;
            d.idx   = opc[2:0];
         end else begin
            case (lo)
               alod_pkg::LO_IMM: begin
                  d.valid  = 1'b1;
                  d.src    = alod_pkg::ALOD_SRC_IMM;
                  d.len    = alod_pkg::LEN_TWO;
               end
               alod_pkg::LO_DIR: begin
                  d.valid  = 1'b1;
                  d.src    = alod_pkg::ALOD_SRC_DIR;
                  d.mem_rd = 1'b1;
                  d.len    = alod_pkg::LEN_TWO;
               end
               alod_pkg::LO_IND0, alod_pkg::LO_IND1: begin
                  d.valid  = 1'b1;
                  d.src    = alod_pkg::ALOD_SRC_IND;
                  d.mem_rd = 1'b1;
                  d.idx    = {2'h0, opc[0]};
               end
               alod_pkg::LO_DIR_ACC: begin
                  if (!arith && d.op != alod_pkg::ALOD_OP_XOR) begin
                     d.valid  = 1'b1;
                     d.src    = alod_pkg::ALOD_SRC_ACC;
                     d.to_dir = 1'b1;
                     d.mem_rd = 1'b1;
                     d.len    = alod_pkg::LEN_TWO;
                  end
               end
               alod_pkg::LO_DIR_IMM: begin
                  if (!arith && d.op != alod_pkg::ALOD_OP_XOR) begin
                     d.valid  = 1'b1;
                     d.src    = alod_pkg::ALOD_SRC_IMM2;
                     d.to_dir = 1'b1;
                     d.mem_rd = 1'b1;
                     d.len    = alod_pkg::LEN_THREE;
                     d.mc     = alod_pkg::MC_TWO;
                  end
               end
               default: d.valid = 1'b0;
            endcase
         end
      end
      if (!d.valid) begin
         d        = '0;
         d.op     = alod_pkg::ALOD_OP_NONE;
         d.src    = alod_pkg::ALOD_SRC_REG;
         d.len    = alod_pkg::LEN_ONE;
         d.mc     = alod_pkg::MC_ONE;
      end
      return d;
   endfunction

   // Result in the low byte; top bit is carry or borrow out, or the unchanged carry in for logic ops
   function automatic logic [8:0] alu(input alod_pkg::alod_op_t op,
                                      input logic [7:0]          a,
                                      input logic [7:0]          b,
                                      input logic                cin);
      logic [8:0] r;
      r = {cin, a};
      case (op)
         alod_pkg::ALOD_OP_ADD:  r = {1'b0, a} + {1'b0, b};
         alod_pkg::ALOD_OP_SUM_WITH_CARRY_OP: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         alod_pkg::ALOD_OP_MINUS_WITH_BORROW_OP: r = {1'b0, a} - {1'b0, b} - {8'h00, cin};
         alod_pkg::ALOD_OP_AND:  r = {cin, a & b};
         alod_pkg::ALOD_OP_OR:   r = {cin, a | b};
         alod_pkg::ALOD_OP_XOR:  r = {cin, a ^ b};
         default:                r = {cin, a};
      endcase
      return r;
   endfunction

   // Clocks an instruction occupies, machine cycles times clock pairs
   function automatic logic [alod_pkg::CNT_W-1:0] span(input logic [2:0] mc);
      logic [alod_pkg::CNT_W-1:0] per;
      per = alod_pkg::CNT_W'(alod_pkg::CLK_PER_MC);
      return alod_pkg::CNT_W'(mc) * per;
   endfunction

   always_comb begin
      alod_pkg::alod_dec_t         dec;
      logic [7:0]                  opnd;
      logic [7:0]                  lhs;
      logic [8:0]                  res;
      logic                        last;
      dec       = decode(ins_opcode);
      opnd      = 8'h00;
      lhs       = 8'h00;
      res       = 9'h000;
      last      = (s_q.cnt == span(s_q.dec.mc) - alod_pkg::CNT_W'(1));
      s_d         = s_q;
      s_d.rd      = 1'b0;
      s_d.wr      = 1'b0;
      s_d.consume = 1'b0;
      s_d.done    = 1'b0;
      s_d.unsup   = 1'b0;

      // Loads from the core; a result of the instruction overrides them
      if (bank_load_en) begin
         s_d.bank[bank_load_idx] = bank_load_data;
      end
      if (acc_load_en) begin
         s_d.acc = acc_load_data;
      end
      if (carry_load_en) begin
         s_d.carry = carry_load_data;
      end

      case (s_q.seq)
         alod_pkg::ALOD_SEQ_IDLE: begin
            s_d.ready = 1'b1;
            if (ins_valid && s_q.ready) begin
               s_d.seq         = alod_pkg::ALOD_SEQ_EXEC;
               s_d.ready       = 1'b0;
               s_d.dec         = dec;
               s_d.b1          = ins_byte1;
               s_d.b2          = ins_byte2;
               s_d.cnt         = alod_pkg::CNT_W'(1);
               s_d.consume     = 1'b1;
               s_d.consume_len = dec.len;
               s_d.unsup       = !dec.valid;
               s_d.rd          = dec.mem_rd;
               if (dec.src == alod_pkg::ALOD_SRC_IND) begin
                  s_d.addr = s_q.bank[dec.idx];
               end else begin
                  s_d.addr = ins_byte1;
               end
            end
         end
         alod_pkg::ALOD_SEQ_EXEC: begin
            case (s_q.dec.src)
               alod_pkg::ALOD_SRC_REG:  opnd = s_q.bank[s_q.dec.idx];
               alod_pkg::ALOD_SRC_DIR:  opnd = dmem_rdata;
               alod_pkg::ALOD_SRC_IND:  opnd = dmem_rdata;
               alod_pkg::ALOD_SRC_IMM:  opnd = s_q.b1;
               alod_pkg::ALOD_SRC_ACC:  opnd = s_q.acc;
               alod_pkg::ALOD_SRC_IMM2: opnd = s_q.b2;
               default:                 opnd = 8'h00;
            endcase
            lhs = s_q.dec.to_dir ? dmem_rdata : s_q.acc;
            res = alu(s_q.dec.op, lhs, opnd, s_q.carry);
            if (s_q.dec.valid) begin
               if (s_q.dec.to_dir) begin
                  // Read-modify-write of the direct byte
                  s_d.wr    = 1'b1;
                  s_d.wdata = res[7:0];
               end else begin
                  s_d.acc   = res[7:0];
                  s_d.carry = res[8];
               end
            end
            s_d.cnt = s_q.cnt + alod_pkg::CNT_W'(1);
            if (last) begin
               s_d.seq     = alod_pkg::ALOD_SEQ_IDLE;
               s_d.ready   = 1'b1;
               s_d.done    = 1'b1;
               s_d.done_mc = s_q.dec.mc;
            end else begin
               s_d.seq     = alod_pkg::ALOD_SEQ_HOLD;
            end
         end
         alod_pkg::ALOD_SEQ_HOLD: begin
            // Pads the slot out to the full machine cycle count
            s_d.cnt = s_q.cnt + alod_pkg::CNT_W'(1);
            if (last) begin
               s_d.seq     = alod_pkg::ALOD_SEQ_IDLE;
               s_d.ready   = 1'b1;
               s_d.done    = 1'b1;
               s_d.done_mc = s_q.dec.mc;
            end
         end
         default: begin
            s_d.seq   = alod_pkg::ALOD_SEQ_IDLE;
            s_d.ready = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ins_ready   = s_q.ready;
   assign consume     = s_q.consume;
   assign consume_len = s_q.consume_len;
   assign dmem_rd     = s_q.rd;
   assign dmem_wr     = s_q.wr;
   assign dmem_addr   = s_q.addr;
   assign dmem_wdata  = s_q.wdata;
   assign acc         = s_q.acc;
   assign carry       = s_q.carry;
   assign done        = s_q.done;
   assign done_mc     = s_q.done_mc;
   assign unsupported = s_q.unsup;

endmodule // alod_decoder

// File: design/alod_pkg.sv
// Purpose: Constants and types for the arithmetic and logic opcode decoder
// Assumes: Single system clock, machine cycle made of system clock pairs
// Notes: Used by the decoder top only, not by the bench

package alod_pkg;

   localparam int unsigned CLK_PER_MC = 2;
   localparam int unsigned CNT_W      = 4;

   localparam logic [1:0] LEN_ONE   = 2'h1;
   localparam logic [1:0] LEN_TWO   = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   localparam logic [2:0] MC_ONE  = 3'h1;
   localparam logic [2:0] MC_TWO  = 3'h2;
   localparam logic [2:0] MC_FOUR = 3'h4;

   localparam logic [3:0] HI_ADD  = 4'h2;
   localparam logic [3:0] HI_SUM_WITH_CARRY_OP = 4'h3;
   localparam logic [3:0] HI_OR   = 4'h4;
   localparam logic [3:0] HI_AND  = 4'h5;
   localparam logic [3:0] HI_XOR  = 4'h6;
   localparam logic [3:0] HI_MINUS_WITH_BORROW_OP = 4'h9;

   localparam logic [3:0] LO_DIR_ACC = 4'h2;
   localparam logic [3:0] LO_DIR_IMM = 4'h3;
   localparam logic [3:0] LO_IMM     = 4'h4;
   localparam logic [3:0] LO_DIR     = 4'h5;
   localparam logic [3:0] LO_IND0    = 4'h6;
   localparam logic [3:0] LO_IND1    = 4'h7;

   localparam int unsigned LO_REG_BIT = 3;

   typedef enum logic [2:0] {
      ALOD_OP_NONE,
      ALOD_OP_ADD,
      ALOD_OP_SUM_WITH_CARRY_OP,
      ALOD_OP_MINUS_WITH_BORROW_OP,
      ALOD_OP_AND,
      ALOD_OP_OR,
      ALOD_OP_XOR
   } alod_op_t;

   typedef enum logic [2:0] {
      ALOD_SRC_REG,
      ALOD_SRC_DIR,
      ALOD_SRC_IND,
      ALOD_SRC_IMM,
      ALOD_SRC_ACC,
      ALOD_SRC_IMM2
   } alod_src_t;

   typedef enum logic [1:0] {
      ALOD_SEQ_IDLE,
      ALOD_SEQ_EXEC,
      ALOD_SEQ_HOLD
   } alod_seq_t;

   typedef struct packed {
      logic      valid;
      alod_op_t  op;
      alod_src_t src;
      logic      to_dir;
      logic      mem_rd;
      logic [2:0] idx;
      logic [1:0] len;
      logic [2:0] mc;
   } alod_dec_t;

   typedef struct packed {
      alod_seq_t          seq;
      logic               ready;
      logic [CNT_W-1:0]   cnt;
      alod_dec_t          dec;
      logic [7:0]         b1;
      logic [7:0]         b2;
      logic [7:0]         acc;
      logic               carry;
      logic [7:0][7:0]    bank;
      logic               rd;
      logic               wr;
      logic [7:0]         addr;
      logic [7:0]         wdata;
      logic               consume;
      logic [1:0]         consume_len;
      logic               done;
      logic [2:0]         done_mc;
      logic               unsup;
   } alod_state_t;

endpackage

// File: tb/alod_decoder_asserts.sv
// Purpose: Port-level timing checks for the opcode decoder
// Assumes: One clock domain, reset active low
// Notes: Attached to the decoder by bind
`timescale 1ns/100ps
module alod_decoder_asserts (
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic       ins_valid,
   input wire logic [7:0] ins_opcode,
   input wire logic [7:0] ins_byte1,
   input wire logic       ins_ready,
   input wire logic       consume,
   input wire logic [1:0] consume_len,
   input wire logic       dmem_rd,
   input wire logic       dmem_wr,
   input wire logic [7:0] dmem_addr,
   input wire logic       done,
   input wire logic [2:0] done_mc
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire take = ins_ready && ins_valid;
   property p_consume; take |=> consume && !ins_ready && !done; endproperty
   a_consume: assert property (p_consume) else $error("no consume after take");
   property p_dir; take && ins_opcode == 8'h25 |=> consume_len == 2'h2 && dmem_rd
      && dmem_addr == $past(ins_byte1); endproperty
   a_dir: assert property (p_dir) else $error("direct add access wrong");
   property p_mc1; take && ins_opcode == 8'h25 |-> ##2 done && done_mc == 3'h1; endproperty
   a_mc1: assert property (p_mc1) else $error("one cycle op timing wrong");
   property p_mc2; take && ins_opcode == 8'h53 |=> !done [*3] ##1 done && done_mc == 3'h2;
   endproperty
   a_mc2: assert property (p_mc2) else $error("two cycle op timing wrong");
   property p_len3; take && (ins_opcode == 8'h53 || ins_opcode == 8'h43)
      |=> consume_len == 2'h3; endproperty
   a_len3: assert property (p_len3) else $error("three byte length wrong");
   property p_reg; take && ins_opcode[7:3] == 5'h07 |=> consume_len == 2'h1 && !dmem_rd
      ##1 done; endproperty
   a_reg: assert property (p_reg) else $error("bank op wrong");
   property p_ind; take && ins_opcode[7:1] == 7'h13 |=> consume_len == 2'h1 && dmem_rd;
   endproperty
   a_ind: assert property (p_ind) else $error("indirect op wrong");
   property p_wr; take && ins_opcode == 8'h53 |-> ##2 dmem_wr
      && dmem_addr == $past(ins_byte1, 2); endproperty
   a_wr: assert property (p_wr) else $error("direct write wrong");
   property p_ready; $rose(ins_ready) |-> done || !$past(reset_n, 2); endproperty
   a_ready: assert property (p_ready) else $error("ready before done");
endmodule // alod_decoder_asserts
bind alod_decoder alod_decoder_asserts chk (.clk, .reset_n, .ins_valid, .ins_opcode,
   .ins_byte1, .ins_ready, .consume, .consume_len, .dmem_rd, .dmem_wr, .dmem_addr,
   .done, .done_mc);

// File: tb/alod_decoder_bench.sv
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Bank register n holds 10h plus n, memory word is address xor A5h
// Notes: Reset values first, then table rows, then a reset in mid-op
`timescale 1ns/100ps
module alod_decoder_bench;
   typedef struct packed {
      logic [7:0] op, b1, b2, a0;
      logic       c0;
      logic [1:0] len;
      logic [2:0] mc;
      logic [7:0] r;
      logic       rc, wr, u;
   } alod_row_t;
   localparam int N = 20;
   localparam alod_row_t ROWS [N] = '{
      '{8'h25,8'h30,8'h0,8'h80,1'h0,2'h2,3'h1,8'h15,1'h1,1'h0,1'h0},
      '{8'h26,8'h0,8'h0,8'h01,1'h1,2'h1,3'h1,8'hB6,1'h0,1'h0,1'h0},
      '{8'h3B,8'h0,8'h0,8'hF0,1'h1,2'h1,3'h1,8'h04,1'h1,1'h0,1'h0},
      '{8'h35,8'h31,8'h0,8'h01,1'h1,2'h2,3'h1,8'h96,1'h0,1'h0,1'h0},
      '{8'h37,8'h0,8'h0,8'h50,1'h0,2'h1,3'h1,8'h04,1'h1,1'h0,1'h0},
      '{8'h34,8'h7F,8'h0,8'h80,1'h1,2'h2,3'h1,8'h00,1'h1,1'h0,1'h0},
      '{8'h9F,8'h0,8'h0,8'h10,1'h1,2'h1,3'h1,8'hF8,1'h1,1'h0,1'h0},
      '{8'h95,8'h32,8'h0,8'hA0,1'h0,2'h2,3'h1,8'h09,1'h0,1'h0,1'h0},
      '{8'h96,8'h0,8'h0,8'hB5,1'h1,2'h1,3'h1,8'hFF,1'h1,1'h0,1'h0},
      '{8'h94,8'h01,8'h0,8'h00,1'h0,2'h2,3'h1,8'hFF,1'h1,1'h0,1'h0},
      '{8'h55,8'h33,8'h0,8'hF0,1'h1,2'h2,3'h1,8'h90,1'h1,1'h0,1'h0},
      '{8'h57,8'h0,8'h0,8'h0F,1'h0,2'h1,3'h1,8'h04,1'h0,1'h0,1'h0},
      '{8'h46,8'h0,8'h0,8'h0A,1'h1,2'h1,3'h1,8'hBF,1'h1,1'h0,1'h0},
      '{8'h68,8'h0,8'h0,8'hFF,1'h0,2'h1,3'h1,8'hEF,1'h0,1'h0,1'h0},
      '{8'h65,8'h34,8'h0,8'h11,1'h1,2'h2,3'h1,8'h80,1'h1,1'h0,1'h0},
      '{8'h67,8'h0,8'h0,8'hB4,1'h0,2'h1,3'h1,8'h00,1'h0,1'h0,1'h0},
      '{8'h53,8'h40,8'h3C,8'h77,1'h1,2'h3,3'h2,8'h24,1'h1,1'h1,1'h0},
      '{8'h43,8'h41,8'h01,8'h00,1'h0,2'h3,3'h2,8'hE5,1'h0,1'h1,1'h0},
      '{8'h52,8'h42,8'h0,8'h0F,1'h1,2'h2,3'h1,8'h07,1'h1,1'h1,1'h0},
      '{8'h00,8'h0,8'h0,8'h5A,1'h1,2'h1,3'h1,8'h5A,1'h1,1'h0,1'h1}};
   logic clk = 1'h0, reset_n = 1'h0, ins_valid = 1'h0, bank_load_en = 1'h0;
   logic acc_load_en = 1'h0, carry_load_en = 1'h0, carry_load_data = 1'h0;
   logic [7:0] ins_opcode = 8'h0, ins_byte1 = 8'h0, ins_byte2 = 8'h0, bank_load_data = 8'h0;
   logic [7:0] acc_load_data = 8'h0, dmem_addr, dmem_wdata, dmem_rdata, acc;
   logic [2:0] bank_load_idx = 3'h0, done_mc;
   logic [1:0] consume_len;
   logic ins_ready, consume, dmem_rd, dmem_wr, carry, done, unsupported;
   int mismatches = 0, comparisons = 0;
   alod_decoder uut (.clk, .reset_n, .ins_valid, .ins_opcode, .ins_byte1, .ins_byte2,
      .ins_ready, .consume, .consume_len, .dmem_rd, .dmem_wr, .dmem_addr, .dmem_wdata,
      .dmem_rdata, .bank_load_en, .bank_load_idx, .bank_load_data, .acc_load_en,
      .acc_load_data, .carry_load_en, .carry_load_data, .acc, .carry, .done, .done_mc,
      .unsupported);
   alod_dmem_model mdl (.clk(clk), .rd(dmem_rd), .wr(dmem_wr), .addr(dmem_addr),
      .wdata(dmem_wdata), .rdata(dmem_rdata));
   always #10 clk = ~clk;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check_reset();
      #1;
      check("ready", {7'h0, ins_ready}, 8'h0);
      check("acc", acc, 8'h0);
      check("strobes", {4'h0, consume, done, dmem_rd, dmem_wr}, 8'h0);
   endtask
   task automatic run_row(input alod_row_t t);
      int n;
      @(posedge clk);
      acc_load_en <= 1'h1;
      acc_load_data <= t.a0;
      carry_load_en <= 1'h1;
      carry_load_data <= t.c0;
      @(posedge clk);
      acc_load_en <= 1'h0;
      carry_load_en <= 1'h0;
      ins_valid <= 1'h1;
      ins_opcode <= t.op;
      ins_byte1 <= t.b1;
      ins_byte2 <= t.b2;
      n = 0;
      do @(posedge clk); while (ins_ready !== 1'h1 && ++n < 20);
      ins_valid <= 1'h0;
      #1;
      check("consume", {7'h0, consume}, 8'h1);
      check("length", {6'h0, consume_len}, {6'h0, t.len});
      check("unsupported", {7'h0, unsupported}, {7'h0, t.u});
      n = 1;
      while (done !== 1'h1 && n < 12) begin
         @(posedge clk);
         #1;
         n++;
      end
      check("cycles", 8'(n), {4'h0, t.mc, 1'h0});
      check("done_mc", {5'h0, done_mc}, {5'h0, t.mc});
      check("acc", acc, t.wr ? t.a0 : t.r);
      check("carry", {7'h0, carry}, {7'h0, t.rc});
      if (t.wr) begin
         // Write strobe stands with done for one-cycle ops, two cycles before it for two-cycle ops; it lands at the end of that cycle
         @(posedge clk);
         #1;
         check("memory", mdl.mem[t.b1], t.r);
      end
   endtask
   initial begin
      #100000;
      mismatches++;
      give_verdict();
   end
   initial begin
      // Reset level from time zero gives no edge, so wait for a clock first
      @(posedge clk);
      check_reset();
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         bank_load_en <= 1'h1;
         bank_load_idx <= 3'(i);
         bank_load_data <= 8'h10 + 8'(i);
      end
      @(posedge clk);
      bank_load_en <= 1'h0;
      for (int i = 0; i < N; i++) begin
         run_row(ROWS[i]);
         $display("test %0d done", i);
      end
      // Reset in the middle of a two-cycle op
      @(posedge clk);
      ins_valid <= 1'h1;
      ins_opcode <= 8'h53;
      repeat (3) @(posedge clk);
      ins_valid <= 1'h0;
      reset_n <= 1'h0;
      check_reset();
      @(posedge clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      check("ready after reset", {7'h0, ins_ready}, 8'h1);
      run_row(ROWS[0]);
      $display("test reset done");
      give_verdict();
   end
endmodule // alod_decoder_bench

// File: tb/alod_dmem_model.sv
// Purpose: Internal data memory on the far side of the decoder
// Assumes: Reads answer in the same cycle, writes land on the edge
// Notes: Shows the inverse of the last word read while not read
`timescale 1ns/100ps
module alod_dmem_model (
   input  wire logic       clk,
   input  wire logic       rd,
   input  wire logic       wr,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [256];
   logic [7:0] last;
   initial begin
      last = 8'h5A;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   end
   always @(posedge clk) begin
      if (wr) mem[addr] <= wdata;
      if (rd) last <= mem[addr];
   end
   assign rdata = rd ? mem[addr] : ~last;
endmodule // alod_dmem_model
